// >>> acc_top.sv
// How it works
// (RULE1) Regulator off: other settings ignored and converter held idle. The protocol power bit is still taken.
// (RULE2) Interrupt enable set: each conversion completion raises an interrupt; clear: none. conv_irq also needs irq_ena bit 0.
// (RULE3) Converter clock is peripheral clock divided by 8, 16, 32 or 64.
// (RULE4) Division counts real pclk edges, so frequency scales with pclk.
// (RULE5) Sampling interval selectable as 2, 4, 6 or 8 converter clocks.
// (RULE6) Input integrated for three sampling intervals per conversion.
// (RULE7) Conversion lasts three intervals plus thirteen converter clocks.
// (RULE8) Reference select chooses external pin or internal reference.
// (RULE9) Band-gap routes to reference pin; software sets it only with internal reference.
// (RULE10) Band-gap setting lost at protocol power off; write then faults.
// (RULE11) Software should pick divide-by-32 for 500kHz from 16MHz.
// (RULE12) Regulator reported powered only after 16 us start-up.
// (RULE13) Reset clears regulator, interrupt enable and band-gap; converter idle.
//
// The register addresses and the APB slave port were decided locally.
module acc_top
  import acc_pkg::*;
(
  input  wire logic        pclk,                 // Peripheral clock, 20 MHz
  input  wire logic        presetn,              // Async reset, active low
  input  wire logic [11:0] paddr,                // APB address
  input  wire logic        psel,                 // APB select
  input  wire logic        penable,              // APB enable
  input  wire logic        pwrite,               // APB direction
  input  wire logic [31:0] pwdata,               // APB write data
  input  wire logic [3:0]  pstrb,                // APB byte strobes
  output logic [31:0]      prdata,               // APB read data
  output logic             pready,               // APB ready
  output logic             pslverr,              // APB error
  output logic             conv_irq,             // Level interrupt
  output logic             reference_source_select, // 1 internal, 0 external
  output logic             bandgap_route_enable, // Band-gap to reference pin
  output logic             integrating,          // Integration window
  output logic             conv_clk_tick         // Converter clock pulse
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                 analog_regulator_enable;
    logic                 conversion_irq_enable;
    logic [1:0]           sample_interval_select;
    logic [1:0]           conv_clock_divide_select;
    logic                 ref_sel;
    logic                 protocol_power;
    logic                 bandgap;
    logic                 access_fault;
    logic                 reg_powered;
    logic [ACC_CNT_W-1:0] pwr_cnt;
    logic [ACC_IRQ_W-1:0] irq_sts;
    logic [ACC_IRQ_W-1:0] irq_ena;
    logic [31:0]          rdata;
  } acc_top_state_t;

  acc_top_state_t state;
  acc_top_state_t next_state;

  logic wr_acc;
  logic rd_acc;
  logic start_req;
  logic busy;
  logic done;
  logic [ACC_IRQ_W-1:0] irq_set;
  logic bg_fault;

  // APB decode; zero-wait slave, answers in the access cycle
  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && penable && !pwrite;
  assign pready  = 1'b1;
  // Fault write answers with an error so software sees the exception
  assign pslverr = bg_fault;  // RULE10

  // Band-gap write with protocol power off is an access exception
  assign bg_fault  = wr_acc && (paddr == ACC_BANDGAP_OFS) && pstrb[0] &&
                     !state.protocol_power;  // RULE10
  assign start_req = wr_acc && (paddr == ACC_CONTROL_OFS) && pstrb[0] &&
                     pwdata[ACC_CTL_START_BIT] && state.reg_powered;

  // ---------------------------------------------------------------
  // Converter clock and sequencer
  // ---------------------------------------------------------------
  acc_clkdiv u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (state.analog_regulator_enable),                      // RULE1
    .div_sel (state.conv_clock_divide_select),
    .tick    (conv_clk_tick)
  );

  acc_conv u_conv (
    .pclk        (pclk),
    .presetn     (presetn),
    .enable      (state.analog_regulator_enable),                  // RULE1
    .tick        (conv_clk_tick),
    .start       (start_req),
    .samp_sel    (state.sample_interval_select),                   // RULE5
    .busy        (busy),
    .integrating (integrating),
    .done        (done)
  );

  // Interrupt events; conversion event only with enable set
  assign irq_set[ACC_IRQ_DONE_BIT]  = done && state.conversion_irq_enable;  // RULE2
  assign irq_set[ACC_IRQ_FAULT_BIT] = bg_fault;

  // ---------------------------------------------------------------
  // Register and power logic
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    // Register writes: configuration, band-gap, interrupt enable and clear
    if (wr_acc && pstrb[0]) begin
      unique case (paddr)
        ACC_CONFIG_OFS: begin
          next_state.analog_regulator_enable  = pwdata[ACC_CFG_REG_BIT];
          next_state.protocol_power           = pwdata[ACC_CFG_PPWR_BIT];
          // Other settings take effect only with regulator on
          if (pwdata[ACC_CFG_REG_BIT]) begin  // RULE1
            next_state.conversion_irq_enable    = pwdata[ACC_CFG_IRQ_BIT];
            next_state.sample_interval_select   = pwdata[ACC_CFG_SAMP_LSB +: 2];  // RULE5
            next_state.conv_clock_divide_select = pwdata[ACC_CFG_DIV_LSB +: 2];   // RULE3
            next_state.ref_sel                  = pwdata[ACC_CFG_REF_BIT];        // RULE8
          end
        end
        ACC_BANDGAP_OFS: begin
          if (state.protocol_power) begin
            next_state.bandgap = pwdata[0];  // RULE9
          end
        end
        ACC_IRQ_ENA_OFS: begin
          next_state.irq_ena = pwdata[ACC_IRQ_W-1:0];
        end
        ACC_IRQ_CLR_OFS: begin
          next_state.irq_sts = state.irq_sts & ~pwdata[ACC_IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
    // Set wins over a clear in the same cycle
    next_state.irq_sts = next_state.irq_sts | irq_set;
    if (bg_fault) begin
      next_state.access_fault = 1'b1;
    end
    // Losing protocol power drops the band-gap routing
    if (!next_state.protocol_power) begin
      next_state.bandgap = 1'b0;  // RULE10
    end
    // Regulator start-up timer
    if (!state.analog_regulator_enable) begin
      next_state.pwr_cnt     = '0;
      next_state.reg_powered = 1'b0;
    end else if (state.pwr_cnt == ACC_CNT_W'(ACC_REG_STARTUP_CYC - 1)) begin  // RULE12
      next_state.reg_powered = 1'b1;
    end else begin
      next_state.pwr_cnt = state.pwr_cnt + ACC_CNT_W'(1);
    end
    // Read data registered for the next access phase
    next_state.rdata = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        ACC_CONFIG_OFS: begin
          next_state.rdata[ACC_CFG_REG_BIT]       = state.analog_regulator_enable;
          next_state.rdata[ACC_CFG_IRQ_BIT]       = state.conversion_irq_enable;
          next_state.rdata[ACC_CFG_SAMP_LSB +: 2] = state.sample_interval_select;
          next_state.rdata[ACC_CFG_DIV_LSB +: 2]  = state.conv_clock_divide_select;
          next_state.rdata[ACC_CFG_REF_BIT]       = state.ref_sel;
          next_state.rdata[ACC_CFG_PPWR_BIT]      = state.protocol_power;
        end
        ACC_BANDGAP_OFS: next_state.rdata[0] = state.bandgap;
        ACC_STATUS_OFS: begin
          next_state.rdata[ACC_STS_PWR_BIT]  = state.reg_powered;  // RULE12
          next_state.rdata[ACC_STS_BUSY_BIT] = busy;
          next_state.rdata[ACC_STS_ERR_BIT]  = state.access_fault;
        end
        ACC_IRQ_STS_OFS: next_state.rdata[ACC_IRQ_W-1:0] = state.irq_sts;
        ACC_IRQ_ENA_OFS: next_state.rdata[ACC_IRQ_W-1:0] = state.irq_ena;
        default: begin
        end
      endcase
    end
  end

  // Reset leaves regulator, irq enable and band-gap off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '0;  // RULE13
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata                  = rd_acc ? state.rdata : 32'h0000_0000;
  assign conv_irq                = |(state.irq_sts & state.irq_ena);
  assign reference_source_select = state.ref_sel;  // RULE8
  // Software keeps band-gap off with external reference; hardware masks it too
  assign bandgap_route_enable    = state.bandgap && (state.ref_sel == ACC_REF_INTERNAL);  // RULE9

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_reg_on;
    $rose(state.analog_regulator_enable);
  endsequence

  AST_REG_NOT_EARLY: assert property (@(posedge pclk) disable iff (!presetn)  // RULE12
    s_reg_on |-> !state.reg_powered [*8])
    else $error("regulator reported powered too early");
  AST_REG_POWERED_LEN: assert property (@(posedge pclk) disable iff (!presetn)  // RULE12
    $rose(state.reg_powered) |-> (state.pwr_cnt == ACC_CNT_W'(ACC_REG_STARTUP_CYC - 1)))
    else $error("regulator start-up not sixteen microseconds");
  // Tick and powered flag are registered, so they drop one cycle later
  AST_REG_OFF_IDLE: assert property (@(posedge pclk) disable iff (!presetn)  // RULE1
    !state.analog_regulator_enable |=> !conv_clk_tick && !state.reg_powered)
    else $error("analogue activity with regulator off");
  AST_IRQ_ON_DONE: assert property (@(posedge pclk) disable iff (!presetn)  // RULE2
    (done && state.conversion_irq_enable && state.irq_ena[ACC_IRQ_DONE_BIT]) |=> conv_irq)
    else $error("no interrupt after completed conversion");
  AST_NO_IRQ_DISABLED: assert property (@(posedge pclk) disable iff (!presetn)  // RULE2
    (done && !state.conversion_irq_enable && !state.irq_sts[ACC_IRQ_DONE_BIT]
     && !(wr_acc && paddr == ACC_CONFIG_OFS)) |=> !state.irq_sts[ACC_IRQ_DONE_BIT])
    else $error("conversion interrupt raised while disabled");
  AST_BG_LOST: assert property (@(posedge pclk) disable iff (!presetn)  // RULE10
    !state.protocol_power |-> !state.bandgap)
    else $error("band-gap routing kept without protocol power");
  AST_BG_FAULT: assert property (@(posedge pclk) disable iff (!presetn)  // RULE10
    bg_fault |=> state.access_fault && state.irq_sts[ACC_IRQ_FAULT_BIT])
    else $error("band-gap write without power not flagged");
  AST_BG_EXT_BLOCK: assert property (@(posedge pclk) disable iff (!presetn)  // RULE9
    (reference_source_select == ACC_REF_EXTERNAL) |-> !bandgap_route_enable)
    else $error("band-gap routed with external reference");

  // Config write that leaves the regulator off
  sequence s_cfg_wr_off;
    wr_acc && pstrb[0] && (paddr == ACC_CONFIG_OFS) && !pwdata[ACC_CFG_REG_BIT];
  endsequence

  // Start accepted by an idle sequencer
  sequence s_start_ok;
    start_req && !busy;
  endsequence

  // Band-gap write with protocol power present
  sequence s_bg_wr_ok;
    wr_acc && pstrb[0] && (paddr == ACC_BANDGAP_OFS) && state.protocol_power;
  endsequence

  AST_CFG_IGNORED: assert property (@(posedge pclk) disable iff (!presetn)  // RULE1
    s_cfg_wr_off |=> $stable(state.sample_interval_select)
      && $stable(state.conv_clock_divide_select) && $stable(state.ref_sel))
    else $error("configuration taken with regulator off");
  AST_START_TAKEN: assert property (@(posedge pclk) disable iff (!presetn)  // RULE6
    s_start_ok |=> busy && integrating)
    else $error("accepted start did not open the window");
  AST_BG_WRITE: assert property (@(posedge pclk) disable iff (!presetn)  // RULE9
    s_bg_wr_ok |=> (state.bandgap == $past(pwdata[0])))
    else $error("band-gap write with power present lost");

  // Converter ticks counted inside the integration window
  logic [ACC_CNT_W-1:0] integ_ticks;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      integ_ticks <= '0;
    end else if (!integrating) begin
      integ_ticks <= '0;
    end else if (conv_clk_tick) begin
      integ_ticks <= integ_ticks + ACC_CNT_W'(1);
    end
  end

  // A window cut short by the regulator going off is not counted
  AST_INTEG_TICKS: assert property (@(posedge pclk) disable iff (!presetn)  // RULE6
    ($fell(integrating) && state.analog_regulator_enable) |->
      ($past(integ_ticks) + ACC_CNT_W'(1) == ACC_CNT_W'(ACC_INTEG_FACTOR) *
       ACC_CNT_W'(acc_samp_periods($past(state.sample_interval_select)))))
    else $error("integration window not three sampling intervals");

endmodule

// >>> acc_pkg.sv
package acc_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] ACC_CONFIG_OFS  = 12'h000;
  localparam logic [11:0] ACC_BANDGAP_OFS = 12'h004;
  localparam logic [11:0] ACC_CONTROL_OFS = 12'h008;
  localparam logic [11:0] ACC_STATUS_OFS  = 12'h00c;
  localparam logic [11:0] ACC_IRQ_STS_OFS = 12'h010;
  localparam logic [11:0] ACC_IRQ_ENA_OFS = 12'h014;
  localparam logic [11:0] ACC_IRQ_CLR_OFS = 12'h018;

  // ---------------------------------------------------------------
  // Configuration field positions
  // ---------------------------------------------------------------
  localparam int ACC_CFG_REG_BIT   = 0;
  localparam int ACC_CFG_IRQ_BIT   = 1;
  localparam int ACC_CFG_SAMP_LSB  = 2;
  localparam int ACC_CFG_DIV_LSB   = 4;
  localparam int ACC_CFG_REF_BIT   = 6;
  localparam int ACC_CFG_PPWR_BIT  = 7;
  localparam logic [31:0] ACC_CFG_RESET = 32'h0000_0000;

  // Control and status bits
  localparam int ACC_CTL_START_BIT = 0;
  localparam int ACC_STS_PWR_BIT   = 0;
  localparam int ACC_STS_BUSY_BIT  = 1;
  localparam int ACC_STS_ERR_BIT   = 2;

  // Interrupt bits: conversion done, band-gap access fault
  localparam int ACC_IRQ_DONE_BIT  = 0;
  localparam int ACC_IRQ_FAULT_BIT = 1;
  localparam int ACC_IRQ_W         = 2;

  // Reference select encoding
  localparam logic ACC_REF_EXTERNAL = 1'b0;
  localparam logic ACC_REF_INTERNAL = 1'b1;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int ACC_PCLK_MHZ       = 20;
  localparam int ACC_REG_STARTUP_US = 16;
  localparam int ACC_REG_STARTUP_CYC = ACC_REG_STARTUP_US * ACC_PCLK_MHZ;
  localparam int ACC_CONV_EXTRA     = 13;
  localparam int ACC_INTEG_FACTOR   = 3;
  localparam int ACC_CNT_W          = 9;

  // Divide ratio 8,16,32,64 from a 2-bit code
  function automatic logic [6:0] acc_div_ratio(input logic [1:0] sel);
    acc_div_ratio = 7'h08 << sel;
  endfunction

  // Sampling interval 2,4,6,8 from a 2-bit code
  function automatic logic [3:0] acc_samp_periods(input logic [1:0] sel);
    acc_samp_periods = {1'b0, sel, 1'b0} + 4'h2;
  endfunction

endpackage

// >>> acc_clkdiv.sv
module acc_clkdiv
  import acc_pkg::*;
(
  input  wire logic       pclk,       // Peripheral clock
  input  wire logic       presetn,    // Async reset, active low
  input  wire logic       run,        // Divider runs while high
  input  wire logic [1:0] div_sel,    // Divide ratio code
  output logic            tick        // One pclk pulse per converter clock
);

  typedef struct packed {
    logic [6:0] cnt;
    logic       tick;
  } acc_div_state_t;

  acc_div_state_t state;
  acc_div_state_t next_state;

  // ---------------------------------------------------------------
  // Divider
  // ---------------------------------------------------------------
  // Counts pclk edges, so the tick rate follows pclk exactly
  always_comb begin
    next_state      = state;
    next_state.tick = 1'b0;
    if (!run) begin
      next_state.cnt = 7'h00;
    end else if (state.cnt >= acc_div_ratio(div_sel) - 7'h01) begin  // RULE3 RULE4
      next_state.cnt  = 7'h00;
      next_state.tick = 1'b1;
    end else begin
      next_state.cnt = state.cnt + 7'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign tick = state.tick;

  // A tick is followed by at least seven quiet cycles, whatever the ratio
  AST_DIV_SPACING: assert property (@(posedge pclk) disable iff (!presetn)  // RULE3
    (tick && run && $stable(div_sel)) |=> !tick [*7])
    else $error("converter clock ticks closer than eight pclk cycles");

endmodule

// >>> acc_conv.sv
module acc_conv
  import acc_pkg::*;
(
  input  wire logic       pclk,       // Peripheral clock
  input  wire logic       presetn,    // Async reset, active low
  input  wire logic       enable,     // Converter allowed to run
  input  wire logic       tick,       // Converter clock pulse
  input  wire logic       start,      // Start one conversion
  input  wire logic [1:0] samp_sel,   // Sampling interval code
  output logic            busy,       // Conversion in progress
  output logic            integrating, // Input integration window
  output logic            done        // One-cycle completion pulse
);

  typedef enum logic [1:0] {IDLE, INTEG, FINISH} acc_conv_phase_t;

  typedef struct packed {
    acc_conv_phase_t        phase;
    logic [ACC_CNT_W-1:0]   cnt;
    logic                   done;
  } acc_conv_state_t;

  acc_conv_state_t state;
  acc_conv_state_t next_state;
  logic [ACC_CNT_W-1:0] integ_len;

  // Window is three sampling intervals of converter clocks
  assign integ_len = ACC_CNT_W'(ACC_INTEG_FACTOR) * ACC_CNT_W'(acc_samp_periods(samp_sel));  // RULE6

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // Total = 3*interval + 13 converter clocks before done
  always_comb begin
    next_state      = state;
    next_state.done = 1'b0;
    if (!enable) begin
      next_state.phase = IDLE;  // RULE1
      next_state.cnt   = '0;
    end else begin
      unique case (state.phase)
        IDLE: begin
          if (start) begin
            next_state.phase = INTEG;
            next_state.cnt   = '0;
          end
        end
        INTEG: begin
          if (tick) begin
            if (state.cnt == integ_len - ACC_CNT_W'(1)) begin  // RULE6
              next_state.phase = FINISH;
              next_state.cnt   = '0;
            end else begin
              next_state.cnt = state.cnt + ACC_CNT_W'(1);
            end
          end
        end
        FINISH: begin
          if (tick) begin
            if (state.cnt == ACC_CNT_W'(ACC_CONV_EXTRA - 1)) begin  // RULE7
              next_state.phase = IDLE;
              next_state.done  = 1'b1;
            end else begin
              next_state.cnt = state.cnt + ACC_CNT_W'(1);
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '{phase: IDLE, cnt: '0, done: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  assign busy        = (state.phase != IDLE);
  assign integrating = (state.phase == INTEG);
  assign done        = state.done;

  // Helper count of converter ticks since start
  logic [ACC_CNT_W-1:0] tick_seen;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_seen <= '0;
    end else if (!busy) begin
      tick_seen <= '0;
    end else if (tick) begin
      tick_seen <= tick_seen + ACC_CNT_W'(1);
    end
  end

  AST_CONV_LENGTH: assert property (@(posedge pclk) disable iff (!presetn)  // RULE7
    $rose(done) |-> ($past(tick_seen) + ACC_CNT_W'(1) == integ_len + ACC_CNT_W'(ACC_CONV_EXTRA)))
    else $error("conversion length not three intervals plus thirteen");
  AST_INTEG_ONLY_BUSY: assert property (@(posedge pclk) disable iff (!presetn)  // RULE6
    integrating |-> busy && !done)
    else $error("integration outside a conversion");
  AST_CONV_GATED: assert property (@(posedge pclk) disable iff (!presetn)  // RULE1
    !enable |=> !busy)
    else $error("converter running without enable");

endmodule

// >>> acc_top_tb.sv
module acc_top_tb
  import acc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // Signals and instance
  // ------------------------------------------------------------
  localparam int TB_LIMIT = 40000; // Sweep needs about 14k cycles
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic        pready, pslverr, conv_irq, ref_sel, bg_en, integ, tick;
  logic        meas, err;
  int          num_errors = 0;
  int          checks_done = 0;
  int          cycle_cnt = 0;
  int          m_cyc, m_integ, last_tick, tick_period;

  acc_top dut (
    .pclk                    (pclk),     // Clock
    .presetn                 (presetn),  // Reset
    .paddr                   (paddr),    // Address
    .psel                    (psel),     // Select
    .penable                 (penable),  // Enable
    .pwrite                  (pwrite),   // Direction
    .pwdata                  (pwdata),   // Write data
    .pstrb                   (pstrb),    // Strobes
    .prdata                  (prdata),   // Read data
    .pready                  (pready),   // Ready
    .pslverr                 (pslverr),  // Error
    .conv_irq                (conv_irq), // Interrupt
    .reference_source_select (ref_sel),  // Reference select
    .bandgap_route_enable    (bg_en),    // Band-gap route
    .integrating             (integ),    // Integration window
    .conv_clk_tick           (tick)      // Converter clock
  );

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Timeout and conversion monitor; counts start after the start write
  always @(posedge pclk) begin
    cycle_cnt++;
    if (cycle_cnt == TB_LIMIT) begin
      num_errors++;
      wrap_up();
    end
    if (meas) begin
      m_cyc++;
      if (integ === 1'b1) m_integ++;
      if (tick === 1'b1) begin
        if (last_tick > 0) tick_period = m_cyc - last_tick;
        last_tick = m_cyc;
      end
    end
  end

  // ------------------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------------------
  task automatic apb_xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                          output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Held until ready is seen high at a rising edge
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic apb_write(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    apb_xfer(1'b1, a, d, dummy);
  endtask

  task automatic apb_read(input logic [11:0] a);
    apb_xfer(1'b0, a, 32'h0, rd);
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Registered outputs land one edge after the write
  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask

  task automatic wrap_up();
    if (num_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One conversion: tolerance of one converter clock for divider phase
  task automatic run_conv(input int s, input int d);
    int sv, dv, n, i;
    sv = 2 * s + 2;
    dv = 8 << d;
    n = 3 * sv + 13;
    apb_write(ACC_CONFIG_OFS, 32'(32'h83 | (s << 2) | (d << 4)));
    m_cyc = 0;
    m_integ = 0;
    last_tick = 0;
    tick_period = 0;
    apb_write(ACC_CONTROL_OFS, 32'h1);
    meas = 1'b1;
    for (i = 0; i < 6000 && conv_irq !== 1'b1; i++) @(posedge pclk);
    meas = 1'b0;
    chk("irq_raised", 1, conv_irq);
    chk("conv_len", 1, m_cyc >= (n - 1) * dv && m_cyc <= (n + 1) * dv + 4);
    chk("integ_len", 1, m_integ >= (3*sv - 1) * dv && m_integ <= (3*sv + 1) * dv);
    chk("tick_period", dv, tick_period);
    apb_read(ACC_IRQ_STS_OFS);
    chk("irq_sts_done", 32'h1, rd);
    apb_write(ACC_IRQ_CLR_OFS, 32'h1);
    settle();
    chk("irq_cleared", 0, conv_irq);
  endtask

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, meas} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // Reset state
    apb_read(ACC_CONFIG_OFS);  chk("config_rst", 32'h0, rd);
    apb_read(ACC_BANDGAP_OFS); chk("bandgap_rst", 32'h0, rd);
    apb_read(ACC_STATUS_OFS);  chk("status_rst", 32'h0, rd);
    apb_read(ACC_IRQ_ENA_OFS); chk("irq_ena_rst", 32'h0, rd);
    chk("outs_rst", 0, {conv_irq, ref_sel, bg_en});
    // Regulator off: fields ignored, start refused
    apb_write(ACC_CONFIG_OFS, 32'h7e);
    apb_read(ACC_CONFIG_OFS);  chk("config_off", 32'h0, rd);
    apb_write(ACC_CONTROL_OFS, 32'h1);
    apb_read(ACC_STATUS_OFS);  chk("status_off", 32'h0, rd);
    // Start-up delay of the regulator
    apb_write(ACC_CONFIG_OFS, 32'h83);
    repeat (290) @(posedge pclk);
    apb_read(ACC_STATUS_OFS);  chk("not_powered", 32'h0, rd);
    repeat (30) @(posedge pclk);
    apb_read(ACC_STATUS_OFS);  chk("powered", 32'h1, rd);
    // Masked completion, then unmask and clear
    apb_write(ACC_CONTROL_OFS, 32'h1);
    repeat (400) @(posedge pclk);
    apb_read(ACC_IRQ_STS_OFS); chk("sts_masked", 32'h1, rd);
    chk("irq_masked", 0, conv_irq);
    apb_write(ACC_IRQ_ENA_OFS, 32'h1);
    settle();
    chk("irq_unmasked", 1, conv_irq);
    apb_write(ACC_IRQ_CLR_OFS, 32'h1);
    settle();
    chk("irq_clr", 0, conv_irq);
    // Every sampling interval against every divide ratio
    for (int s = 0; s < 4; s++) begin
      for (int d = 0; d < 4; d++) begin
        run_conv(s, d);
      end
    end
    // Conversion interrupt enable clear: no interrupt
    apb_write(ACC_CONFIG_OFS, 32'h81);
    apb_write(ACC_CONTROL_OFS, 32'h1);
    repeat (400) @(posedge pclk);
    apb_read(ACC_IRQ_STS_OFS); chk("sts_no_irq", 32'h0, rd);
    apb_read(ACC_STATUS_OFS);  chk("conv_finished", 32'h1, rd);
    chk("irq_quiet", 0, conv_irq);
    // Reference and band-gap routing
    apb_write(ACC_CONFIG_OFS, 32'hc1);
    settle();
    chk("ref_internal", 1, ref_sel);
    apb_write(ACC_BANDGAP_OFS, 32'h1);
    settle();
    chk("bg_on", 1, bg_en);
    chk("slverr_ok", 0, err);
    apb_read(ACC_BANDGAP_OFS); chk("bg_reg", 32'h1, rd);
    apb_write(ACC_CONFIG_OFS, 32'h81);
    settle();
    chk("ref_external", 0, ref_sel);
    chk("bg_masked", 0, bg_en);
    // Protocol power off loses the setting and faults a write
    apb_write(ACC_CONFIG_OFS, 32'h41);
    settle();
    apb_read(ACC_BANDGAP_OFS); chk("bg_lost", 32'h0, rd);
    chk("bg_lost_pin", 0, bg_en);
    apb_write(ACC_BANDGAP_OFS, 32'h1);
    chk("slverr_fault", 1, err);
    apb_read(ACC_STATUS_OFS);  chk("status_fault", 32'h5, rd);
    apb_read(ACC_IRQ_STS_OFS); chk("sts_fault", 32'h2, rd);
    // Regulator switched off mid-run: conversion stopped
    apb_write(ACC_CONTROL_OFS, 32'h1);
    apb_read(ACC_STATUS_OFS);  chk("busy_on", 32'h2, rd & 32'h2);
    apb_write(ACC_CONFIG_OFS, 32'h0);
    settle();
    apb_read(ACC_STATUS_OFS);  chk("busy_off", 32'h0, rd & 32'h2);
    // Unmapped place reads zero and ignores writes
    apb_read(12'h100);         chk("unmapped_rd", 32'h0, rd);
    apb_write(12'h100, 32'hffff_ffff);
    apb_read(ACC_IRQ_ENA_OFS); chk("irq_ena_kept", 32'h1, rd);
    wrap_up();
  end
endmodule
